// [core/rsc_top.sv]
// Reset status/control block with APB slave
//
// The APB interface to the registers was chosen for this implementation.
`include "rsc_map.svh"

module rsc_top
    import rsc_pkg::*;
#(
    parameter int SETTLE_CYC = `RSC_SETTLE_CYC
)
(
    // APB
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Reset sources and processor status
    input  wire logic        external_reset_pin,
    input  wire logic        watchdog_reset_event,
    input  wire logic        cpu_global_irq_en,
    input  wire logic        irq_pending,
    input  wire logic        clock_sel_by_fw,
    // Processor control
    output rsc_cpu_ctl_t     cpu_ctl,
    output logic             watchdog_enable,
    output logic             sleep_timer_reset,
    output logic             cpu_irq_disable,
    output logic             irq
);

    // ------------------------------------------------------------------------
    // Pin synchroniser and pulse filter
    // ------------------------------------------------------------------------
    logic [2:0]               pin_sync_reg;
    logic [2:0]               pin_sync_next;
    logic [`RSC_CNT_W-1:0]    pin_cnt_reg;
    logic [`RSC_CNT_W-1:0]    pin_cnt_next;
    logic                     pin_lvl_reg;
    logic                     pin_lvl_next;
    logic                     pin_por;

    always_comb
    begin
        pin_sync_next = {pin_sync_reg[1:0], external_reset_pin};
        pin_lvl_next  = pin_lvl_reg;
        if (pin_sync_reg[2] == pin_sync_reg[1])
        begin
            pin_lvl_next = pin_sync_reg[2];
        end
        pin_cnt_next = '0;
        if (pin_lvl_reg && pin_cnt_reg != `RSC_CNT_W'(`RSC_PIN_CYC))
        begin
            pin_cnt_next = pin_cnt_reg + 1'b1;
        end
        else if (pin_lvl_reg)
        begin
            pin_cnt_next = pin_cnt_reg;
        end
    end

    // Fires once per held pulse; a short glitch never reaches the count
    assign pin_por = pin_lvl_reg && (pin_cnt_reg == `RSC_CNT_W'(`RSC_PIN_CYC - 1));

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_sync_reg <= 3'h0;
            pin_cnt_reg  <= '0;
            pin_lvl_reg  <= 1'b0;
        end
        else
        begin
            pin_sync_reg <= pin_sync_next;
            pin_cnt_reg  <= pin_cnt_next;
            pin_lvl_reg  <= pin_lvl_next;
        end
    end

    // ------------------------------------------------------------------------
    // Reset sequencing and status/control register
    // ------------------------------------------------------------------------
    rsc_state_t               state_reg;
    rsc_state_t               state_next;
    logic [7:0]               scr_reg;
    logic [7:0]               scr_next;
    logic [`RSC_CNT_W-1:0]    settle_reg;
    logic [`RSC_CNT_W-1:0]    settle_next;
    logic                     wd_en_reg;
    logic                     wd_en_next;
    logic                     por_init_reg;
    logic                     por_init_next;
    rsc_cpu_ctl_t             ctl_reg;
    rsc_cpu_ctl_t             ctl_next;
    logic                     stres_reg;
    logic                     stres_next;
    logic                     irqdis_reg;
    logic                     irqdis_next;
    logic                     bank_reg;
    logic                     bank_next;
    logic [`RSC_IRQ_W-1:0]    ist_reg;
    logic [`RSC_IRQ_W-1:0]    ist_next;
    logic [`RSC_IRQ_W-1:0]    imask_reg;
    logic [`RSC_IRQ_W-1:0]    imask_next;
    logic [31:0]              rdata_reg;
    logic [31:0]              rdata_next;
    logic                     ready_reg;
    logic                     ready_next;
    logic                     err_reg;
    logic                     err_next;
    logic                     irq_reg;
    logic                     irq_next;
    logic                     wd_take;
    logic                     por_take;
    logic                     wr;
    logic                     rd;
    logic [`RSC_IRQ_W-1:0]    ev;

    function automatic logic is_mapped(input logic [11:0] a);
        is_mapped = (a == `RSC_SCR_ADDR) || (a == `RSC_IRQ_STAT_ADDR) || (a == `RSC_IRQ_MASK_ADDR)
                 || (a == `RSC_BANK_ADDR) || (a == `RSC_CTRL_ADDR) || (a == `RSC_STATUS_ADDR);
    endfunction

    // One wait state; a write lands only at the edge that completes it
    assign wr = psel && penable && pwrite && ready_reg;
    assign rd = psel && penable && !pwrite && !ready_reg;

    assign por_take = por_init_reg || pin_por;
    assign wd_take  = watchdog_reset_event && wd_en_reg && !scr_reg[`RSC_BIT_PWR_FLAG] && !por_take;

    always_comb
    begin
        state_next    = state_reg;
        scr_next      = scr_reg;
        settle_next   = settle_reg;
        wd_en_next    = wd_en_reg;
        por_init_next = 1'b0;
        ctl_next      = ctl_reg;
        stres_next    = 1'b0;
        irqdis_next   = 1'b0;
        bank_next     = bank_reg;
        imask_next    = imask_reg;
        ev            = '0;
        ctl_next.run  = (state_reg == RSC_ST_RUN);
        ctl_next.int_clock_sel = ctl_reg.int_clock_sel && !clock_sel_by_fw;
        scr_next[`RSC_BIT_IRQ_EN] = cpu_global_irq_en;
        case (state_reg)
            RSC_ST_SETTLE:
            begin
                if (settle_reg == '0)
                begin
                    state_next = RSC_ST_RUN;
                end
                else
                begin
                    settle_next = settle_reg - 1'b1;
                end
            end
            RSC_ST_RUN:
            begin
                if (scr_reg[`RSC_BIT_STOP])
                begin
                    state_next = RSC_ST_HALT;
                end
                else if (scr_reg[`RSC_BIT_SLEEP])
                begin
                    state_next = RSC_ST_SLEEP;
                end
            end
            RSC_ST_SLEEP:
            begin
                if (irq_pending)
                begin
                    state_next = RSC_ST_RUN;
                    scr_next[`RSC_BIT_SLEEP] = 1'b0;
                    ev[`RSC_IRQ_WAKE] = 1'b1;
                end
            end
            RSC_ST_HALT:
            begin
                state_next = RSC_ST_HALT;
            end
            default:
            begin
                state_next = RSC_ST_RUN;
            end
        endcase
        if (wr && paddr == `RSC_SCR_ADDR)
        begin
            // Flags only clear on write; a write of one leaves them alone
            scr_next[`RSC_BIT_WD_FLAG]  = scr_reg[`RSC_BIT_WD_FLAG] & pwdata[`RSC_BIT_WD_FLAG];
            scr_next[`RSC_BIT_PWR_FLAG] = scr_reg[`RSC_BIT_PWR_FLAG] & pwdata[`RSC_BIT_PWR_FLAG];
            scr_next[`RSC_BIT_SLEEP]    = pwdata[`RSC_BIT_SLEEP];
            scr_next[`RSC_BIT_STOP]     = pwdata[`RSC_BIT_STOP];
            if (scr_reg[`RSC_BIT_PWR_FLAG] && !pwdata[`RSC_BIT_PWR_FLAG])
            begin
                wd_en_next = 1'b1;
            end
        end
        if (wr && paddr == `RSC_IRQ_MASK_ADDR)
        begin
            imask_next = pwdata[`RSC_IRQ_W-1:0];
        end
        if (wr && paddr == `RSC_BANK_ADDR)
        begin
            bank_next = pwdata[0];
        end
        scr_next[6] = 1'b0;
        scr_next[2] = 1'b0;
        scr_next[1] = 1'b0;
        // Any reset overrides software writes of the same cycle, except a write that clears interrupt status bits
        if (por_take || wd_take)
        begin
            scr_next = {cpu_global_irq_en, 1'b0, scr_reg[`RSC_BIT_WD_FLAG], 5'h00} & 8'h80;
            scr_next[`RSC_BIT_WD_FLAG]  = scr_reg[`RSC_BIT_WD_FLAG] | wd_take;
            scr_next[`RSC_BIT_PWR_FLAG] = scr_reg[`RSC_BIT_PWR_FLAG] & !por_take;
            ctl_next.start_addr    = `RSC_START_ADDR;
            ctl_next.int_clock_sel = 1'b1;
            ctl_next.run           = 1'b0;
            stres_next             = 1'b1;
            irqdis_next            = 1'b1;
            imask_next             = '0;
            bank_next              = 1'b0;
            state_next             = RSC_ST_RUN;
            ev[`RSC_IRQ_WD]        = wd_take;
        end
        if (por_take)
        begin
            scr_next      = `RSC_SCR_RESET;
            scr_next[`RSC_BIT_IRQ_EN] = cpu_global_irq_en;
            ctl_next.clk_div = `RSC_CLKDIV_POR;
            wd_en_next    = 1'b0;
            settle_next   = `RSC_CNT_W'(SETTLE_CYC - 1);
            state_next    = RSC_ST_SETTLE;
            ev[`RSC_IRQ_POR] = 1'b1;
        end
    end

    // Register bank select does not change the status/control decode
    always_comb
    begin
        ready_next = psel && penable && !ready_reg;
        err_next   = psel && penable && !ready_reg && !is_mapped(paddr);
        rdata_next = rdata_reg;
        ist_next   = ist_reg;
        if (wr && paddr == `RSC_IRQ_STAT_ADDR)
        begin
            ist_next = ist_reg & ~pwdata[`RSC_IRQ_W-1:0];
        end
        ist_next = ist_next | ev;
        irq_next = |(ist_next & imask_next);
        if (rd)
        begin
            case (paddr)
                `RSC_SCR_ADDR:      rdata_next = {24'h000000, scr_reg};
                `RSC_IRQ_STAT_ADDR: rdata_next = {29'h0, ist_reg};
                `RSC_IRQ_MASK_ADDR: rdata_next = {29'h0, imask_reg};
                `RSC_BANK_ADDR:     rdata_next = {31'h0, bank_reg};
                `RSC_CTRL_ADDR:     rdata_next = {29'h0, ctl_reg.clk_div};
                `RSC_STATUS_ADDR:   rdata_next = {26'h0, wd_en_reg, ctl_reg.int_clock_sel, state_reg};
                default:            rdata_next = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg    <= RSC_ST_SETTLE;
            scr_reg      <= `RSC_SCR_RESET;
            settle_reg   <= '0;
            wd_en_reg    <= 1'b0;
            por_init_reg <= 1'b1;
            ctl_reg      <= '{run: 1'b0, int_clock_sel: 1'b1, clk_div: `RSC_CLKDIV_POR, start_addr: `RSC_START_ADDR};
            stres_reg    <= 1'b1;
            irqdis_reg   <= 1'b1;
            bank_reg     <= 1'b0;
            ist_reg      <= '0;
            imask_reg    <= '0;
            rdata_reg    <= 32'h00000000;
            ready_reg    <= 1'b0;
            err_reg      <= 1'b0;
            irq_reg      <= 1'b0;
        end
        else
        begin
            state_reg    <= state_next;
            scr_reg      <= scr_next;
            settle_reg   <= settle_next;
            wd_en_reg    <= wd_en_next;
            por_init_reg <= por_init_next;
            ctl_reg      <= ctl_next;
            stres_reg    <= stres_next;
            irqdis_reg   <= irqdis_next;
            bank_reg     <= bank_next;
            ist_reg      <= ist_next;
            imask_reg    <= imask_next;
            rdata_reg    <= rdata_next;
            ready_reg    <= ready_next;
            err_reg      <= err_next;
            irq_reg      <= irq_next;
        end
    end

    assign prdata            = rdata_reg;
    assign pready            = ready_reg;
    assign pslverr           = err_reg;
    assign cpu_ctl           = ctl_reg;
    assign watchdog_enable   = wd_en_reg;
    assign sleep_timer_reset = stres_reg;
    assign cpu_irq_disable   = irqdis_reg;
    assign irq               = irq_reg;

endmodule // rsc_top

// [core/rsc_map.svh]
// Register map, field positions and timing counts of the reset status/control block
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`ifndef RSC_MAP_SVH
`define RSC_MAP_SVH

`define RSC_SCR_INDEX       8'hff
`define RSC_SCR_ADDR        12'h3fc
`define RSC_IRQ_STAT_ADDR   12'h400
`define RSC_IRQ_MASK_ADDR   12'h404
`define RSC_BANK_ADDR       12'h408
`define RSC_CTRL_ADDR       12'h40c
`define RSC_STATUS_ADDR     12'h410

`define RSC_BIT_IRQ_EN      7
`define RSC_BIT_WD_FLAG     5
`define RSC_BIT_PWR_FLAG    4
`define RSC_BIT_SLEEP       3
`define RSC_BIT_STOP        0
`define RSC_SCR_RESET       8'h10
`define RSC_SCR_WMASK       8'h39

`define RSC_IRQ_POR         0
`define RSC_IRQ_WD          1
`define RSC_IRQ_WAKE        2
`define RSC_IRQ_W           3

`define RSC_START_ADDR      16'h0000
`define RSC_CLKDIV_POR      3'h3
`define RSC_CLKDIV_W        3
`define RSC_CLK_HZ          25000000
`define RSC_SETTLE_MS       64
`define RSC_SETTLE_CYC      ((`RSC_CLK_HZ / 1000) * `RSC_SETTLE_MS)
`define RSC_PIN_NS          10000
`define RSC_PIN_CYC         ((`RSC_PIN_NS + 39) / 40)
`define RSC_CNT_W           24

`endif

// [core/rsc_pkg.sv]
// Types of the reset status/control block
package rsc_pkg;
    typedef enum logic [3:0] {
        RSC_ST_SETTLE = 4'b0001,
        RSC_ST_RUN    = 4'b0010,
        RSC_ST_SLEEP  = 4'b0100,
        RSC_ST_HALT   = 4'b1000
    } rsc_state_t;

    typedef struct packed {
        logic        run;
        logic        int_clock_sel;
        logic [2:0]  clk_div;
        logic [15:0] start_addr;
    } rsc_cpu_ctl_t;
endpackage

// [tb/rsc_asserts.sv]
// Concurrent checks on the ports of the reset status/control block
module rsc_asserts
    import rsc_pkg::*;
(
    // Clock and reset
    input wire logic         pclk,
    input wire logic         presetn,
    // Register bus
    input wire logic         psel,
    input wire logic         penable,
    input wire logic         pwrite,
    input wire logic [11:0]  paddr,
    input wire logic [31:0]  prdata,
    input wire logic         pready,
    input wire logic         pslverr,
    // Core and reset sources
    input wire logic         watchdog_reset_event,
    input wire logic         cpu_global_irq_en,
    input wire logic         clock_sel_by_fw,
    input wire rsc_cpu_ctl_t cpu_ctl,
    input wire logic         watchdog_enable,
    input wire logic         sleep_timer_reset,
    input wire logic         cpu_irq_disable
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_wait; psel && penable && !pready |=> pready; endproperty
    a_wait: assert property (p_wait) else $error("pready late");
    property p_decode; pready |-> pslverr == !(paddr inside {12'h3fc, 12'h400, 12'h404, 12'h408, 12'h40c, 12'h410}); endproperty
    a_decode: assert property (p_decode) else $error("decode wrong");
    property p_irq_off; watchdog_reset_event && watchdog_enable |=> ##[0:3] cpu_irq_disable; endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq not disabled");
    property p_tmr; watchdog_reset_event && watchdog_enable |=> ##[0:3] sleep_timer_reset; endproperty
    a_tmr: assert property (p_tmr) else $error("timer not reset");
    property p_start; $rose(cpu_ctl.run) |-> cpu_ctl.start_addr == 16'h0000; endproperty
    a_start: assert property (p_start) else $error("start address wrong");
    property p_intclk; cpu_irq_disable && !clock_sel_by_fw |-> ##[1:4] cpu_ctl.int_clock_sel; endproperty
    a_intclk: assert property (p_intclk) else $error("internal clock not chosen");
    property p_mirror; pready && !pwrite && paddr == 12'h3fc |-> prdata[7] == $past(cpu_global_irq_en, 2); endproperty
    a_mirror: assert property (p_mirror) else $error("enable mirror wrong");
    property p_rsvd; pready && !pwrite && paddr == 12'h3fc |-> prdata[31:8] == 24'h0 && prdata[6] == 1'b0 && prdata[2:1] == 2'h0; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
    property p_no_wd; watchdog_reset_event && !watchdog_enable |=> !cpu_irq_disable [*3]; endproperty
    a_no_wd: assert property (p_no_wd) else $error("watchdog acted while off");
    property p_wd_keep; watchdog_enable && watchdog_reset_event |=> watchdog_enable [*3]; endproperty
    a_wd_keep: assert property (p_wd_keep) else $error("watchdog dropped");

    c_run: cover property ($rose(cpu_ctl.run));
    c_err: cover property (pready && pslverr);
    c_wd: cover property (watchdog_reset_event && watchdog_enable);
endmodule // rsc_asserts

bind rsc_top rsc_asserts u_asserts (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .watchdog_reset_event(watchdog_reset_event),
    .cpu_global_irq_en(cpu_global_irq_en), .clock_sel_by_fw(clock_sel_by_fw), .cpu_ctl(cpu_ctl),
    .watchdog_enable(watchdog_enable), .sleep_timer_reset(sleep_timer_reset), .cpu_irq_disable(cpu_irq_disable)
);

// [tb/rsc_cpu_model.sv]
// Processor core stand-in: global interrupt enable flag
module rsc_cpu_model
(
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Core side
    input  wire logic ie_set,
    input  wire logic cpu_irq_disable,
    output logic      cpu_global_irq_en
);
    timeunit 1ns;
    timeprecision 1ps;
    // Disable wins over a same-cycle enable, as on the real core
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            cpu_global_irq_en <= 1'b0;
        else if (cpu_irq_disable)
            cpu_global_irq_en <= 1'b0;
        else if (ie_set)
            cpu_global_irq_en <= 1'b1;
endmodule // rsc_cpu_model

// [tb/reset_status_control_tb.sv]
// Self-checking bench for the reset status/control block
module reset_status_control_tb
    import rsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0]  paddr = 12'h000;
    logic [31:0]  pwdata = 32'h0, prdata;
    logic         ext_pin = 0, wd_evt = 0, ie_set = 0, irq_pend = 0, clk_sel = 0;
    logic         pready, pslverr, ie, wd_en, irq, irq_dis;
    rsc_cpu_ctl_t ctl;
    logic [32:0]  exp_q[$];
    int           failures = 0, checked = 0, seed = 25;

    rsc_top #(.SETTLE_CYC(20)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_reset_pin(ext_pin), .watchdog_reset_event(wd_evt), .cpu_global_irq_en(ie), .irq_pending(irq_pend),
        .clock_sel_by_fw(clk_sel), .cpu_ctl(ctl), .watchdog_enable(wd_en), .sleep_timer_reset(),
        .cpu_irq_disable(irq_dis), .irq(irq));
    rsc_cpu_model u_cpu (.pclk(pclk), .presetn(presetn), .ie_set(ie_set), .cpu_irq_disable(irq_dis),
        .cpu_global_irq_en(ie));

    initial
    begin
        forever #20 pclk = ~pclk;
    end

    // ------------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------------
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // Idle edge first, so back-to-back calls never drive psel twice in one step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
            @(posedge pclk);
        while (pready !== 1'b1 && ++n < 50);
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50)
            failures++;
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic pulse_wd();
        wd_evt <= 1'b1;
        cyc(1);
        wd_evt <= 1'b0;
        cyc(5);
    endtask
    task automatic wait_run(input logic v);
        int n;
        n = 0;
        do
            @(posedge pclk);
        while (ctl.run !== v && ++n < 600);
        if (n >= 600)
            failures++;
    endtask
    task automatic results();
        // A read whose answer never came is a mismatch too
        if (exp_q.size() != 0)
            failures++;
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Read results are judged where they appear, against the oldest note
    always @(posedge pclk)
        if (pready === 1'b1 && psel === 1'b1 && pwrite === 1'b0 && exp_q.size() > 0)
            chk({pslverr, prdata}, exp_q.pop_front());

    initial
    begin
        #(40 * 20000);
        failures++;
        results();
    end

    initial
    begin
        cyc(4);
        presetn <= 1'b1;
        wait_run(1'b1);
        chk(ctl.clk_div, 3'h3);
        chk(ctl.int_clock_sel, 1'b1);
        chk(ctl.start_addr, 16'h0000);
        rd(12'h3fc, 33'h10);
        rd(12'h400, 33'h1);
        pulse_wd();
        chk(ctl.run, 1'b1);
        $display("power-on test done");
        ie_set <= 1'b1;
        cyc(1);
        ie_set <= 1'b0;
        cyc(3);
        apb(1'b1, 12'h3fc, ($random(seed) | 32'h30) & 32'hffff_fff6);
        rd(12'h3fc, 33'h90);
        rd(12'h7f0, 33'h1_0000_0000);
        chk(irq, 1'b0);
        apb(1'b1, 12'h404, 32'h1);
        cyc(3);
        chk(irq, 1'b1);
        apb(1'b1, 12'h400, 32'h1);
        cyc(3);
        chk(irq, 1'b0);
        rd(12'h400, 33'h0);
        $display("flag and interrupt test done");
        apb(1'b1, 12'h408, 32'h1);
        apb(1'b1, 12'h3fc, 32'h0);
        cyc(3);
        chk(wd_en, 1'b1);
        rd(12'h3fc, 33'h80);
        apb(1'b1, 12'h3fc, 32'h8);
        wait_run(1'b0);
        rd(12'h3fc, 33'h88);
        irq_pend <= 1'b1;
        wait_run(1'b1);
        irq_pend <= 1'b0;
        rd(12'h3fc, 33'h80);
        $display("sleep test done");
        clk_sel <= 1'b1;
        cyc(1);
        clk_sel <= 1'b0;
        cyc(3);
        chk(ctl.int_clock_sel, 1'b0);
        pulse_wd();
        wait_run(1'b1);
        chk(ctl.int_clock_sel, 1'b1);
        chk(wd_en, 1'b1);
        rd(12'h3fc, 33'h20);
        $display("watchdog test done");
        apb(1'b1, 12'h3fc, 32'h1);
        wait_run(1'b0);
        cyc(50);
        chk(ctl.run, 1'b0);
        ext_pin <= 1'b1;
        cyc(260);
        ext_pin <= 1'b0;
        wait_run(1'b1);
        chk(wd_en, 1'b0);
        chk(ctl.clk_div, 3'h3);
        rd(12'h3fc, 33'h10);
        $display("halt and pin test done");
        cyc(5);
        results();
    end
endmodule // reset_status_control_tb
